// file: enclave_page_writeback.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

// What this block does
// - misaligned operand block or page: gp fault
// - page outside the protected page cache: page fault
// - misaligned slot: gp fault; slot outside the cache: page fault
// - page and slot in one protected page: gp fault
// - nonzero operand fields or misaligned pointers: gp fault
// - target, slot or control page busy, or slot page changing: gp
// - invalid target or bad version slot page: page fault
// - child page with bad prior blocking step: gp fault
// - unblocked child page: not-blocked code, zero flag, no writes
// - tracking incomplete: not-tracked code, zero flag, no writes
// - child page: owner identifier into header and metadata
// - control page with children: child-present; else header id zero
// - version array page: both identifiers zero
// - header cleared, then filled from the target entry
// - gcm encryption, counter is version shifted by 32, header as aad
// - metadata fields written, reserved zeroed, address returned
// - occupied slot: slot-occupied code and carry, slot still written
// - other flags cleared, result zeroed before the type checks
// - tracking resource in use: gp fault
// - eviction only at the most privileged level
module enclave_page_writeback #(
  parameter logic [63:0] CACHE_BASE = 64'h0000_0000_8000_0000,
  parameter logic [63:0] CACHE_SIZE = 64'h0000_0000_0100_0000
) (
  input  wire logic                                      clk,
  input  wire logic                                      rst,
  input  wire logic [page_writeback_pkg::REG_AW-1:0]     reg_addr,
  input  wire logic [page_writeback_pkg::REG_DW-1:0]     reg_wdata,
  input  wire logic                                      reg_wr,
  input  wire logic                                      reg_rd,
  output logic      [page_writeback_pkg::REG_DW-1:0]     reg_rdata,
  input  wire logic [1:0]                                priv_level,
  input  wire page_writeback_pkg::operand_block_t        operand_block,
  input  wire page_writeback_pkg::page_map_entry_t       target_entry,
  input  wire page_writeback_pkg::page_map_entry_t       slot_page_entry,
  input  wire page_writeback_pkg::owner_info_t           owner_info,
  input  wire page_writeback_pkg::concurrency_t          concurrency,
  input  wire logic [63:0]                               slot_value,
  output logic                                           gcm_start,
  output logic [95:0]                                    gcm_counter,
  output page_writeback_pkg::auth_header_t               gcm_header,
  output logic [63:0]                                    gcm_src_addr,
  output logic [63:0]                                    gcm_dst_addr,
  input  wire logic                                      gcm_done,
  input  wire logic [127:0]                              gcm_tag,
  output logic                                           meta_wr,
  output logic [63:0]                                    meta_addr,
  output page_writeback_pkg::page_crypto_metadata_t      meta_data,
  output logic                                           lin_return_wr,
  output logic [63:0]                                    lin_return,
  output logic                                           slot_wr,
  output logic [63:0]                                    slot_addr,
  output logic [63:0]                                    slot_wdata,
  output logic                                           map_invalidate,
  output logic [63:0]                                    map_invalidate_addr,
  output logic                                           fault_gp,
  output logic                                           fault_pf,
  output logic [63:0]                                    fault_addr,
  output logic                                           busy
);
  import page_writeback_pkg::*;

  function automatic logic is_aligned(input logic [63:0] a,
                                      input int unsigned lg);
    logic [63:0] mask;
    mask = (64'h1 << lg) - 64'h1;
    return (a & mask) == 64'h0;
  endfunction : is_aligned

  function automatic logic in_cache(input logic [63:0] a);
    return (a >= CACHE_BASE) && (a < CACHE_BASE + CACHE_SIZE);
  endfunction : in_cache

  function automatic logic child_type(input logic [7:0] t);
    return (t == regular_page_type) || (t == thread_control_type) ||
           (t == trimmed_page_type);
  endfunction : child_type

  wb_state_t    state_reg, state_next;
  logic [63:0]  operand_addr_reg;
  logic [63:0]  page_addr_reg;
  logic [63:0]  slot_addr_reg;
  logic [63:0]  version_value_reg;
  logic [7:0]   result_reg;
  logic [FLAG_W-1:0] flags_reg;
  logic         done_reg;
  logic         gp_reg;
  logic         pf_reg;
  logic [63:0]  fault_addr_reg;
  logic [63:0]  hdr_id_reg;
  logic [63:0]  meta_id_reg;
  logic [63:0]  meta_ptr_reg;
  logic [63:0]  src_ptr_reg;
  logic         start_cmd;

  // decision made in the check cycle
  logic         chk_gp;
  logic         chk_pf;
  logic [63:0]  chk_faddr;
  logic         chk_stop;
  logic [7:0]   chk_code;
  logic [63:0]  chk_hdr_id;
  logic [63:0]  chk_meta_id;

  assign start_cmd = reg_wr && (reg_addr == OFF_CONTROL) &&
                     reg_wdata[CTRL_START_BIT] && (state_reg == ST_IDLE);

  // operand registers, writable only while idle
  always_ff @(posedge clk) begin
    if (rst) begin
      operand_addr_reg  <= 64'h0;
      page_addr_reg     <= 64'h0;
      slot_addr_reg     <= 64'h0;
      version_value_reg <= 64'h0;
    end else if (reg_wr && state_reg == ST_IDLE) begin
      case (reg_addr)
        OFF_OPERAND: operand_addr_reg  <= reg_wdata;
        OFF_PAGE:    page_addr_reg     <= reg_wdata;
        OFF_SLOT:    slot_addr_reg     <= reg_wdata;
        OFF_VERSION: version_value_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // checks in order, first failing one wins
  always_comb begin
    chk_gp       = 1'b0;
    chk_pf       = 1'b0;
    chk_faddr    = 64'h0;
    chk_stop     = 1'b0;
    chk_code     = success_code;
    chk_hdr_id   = 64'h0;
    chk_meta_id  = 64'h0;
    if (priv_level != 2'b00) begin
      chk_gp = 1'b1;
    end else if (!is_aligned(operand_addr_reg, OPERAND_ALIGN_LG) ||
                 !is_aligned(page_addr_reg, PAGE_ALIGN_LG)) begin
      chk_gp = 1'b1;
    end else if (!in_cache(page_addr_reg)) begin
      chk_pf    = 1'b1;
      chk_faddr = page_addr_reg;
    end else if (!is_aligned(slot_addr_reg, SLOT_ALIGN_LG)) begin
      chk_gp = 1'b1;
    end else if (!in_cache(slot_addr_reg)) begin
      chk_pf    = 1'b1;
      chk_faddr = slot_addr_reg;
    end else if (page_addr_reg[63:PAGE_ALIGN_LG] ==
                 slot_addr_reg[63:PAGE_ALIGN_LG]) begin
      chk_gp = 1'b1;
    end else if (operand_block.lin_addr != 64'h0 ||
                 operand_block.ctrl_ptr != 64'h0) begin
      chk_gp = 1'b1;
    end else if (!is_aligned(operand_block.meta_ptr, META_ALIGN_LG) ||
                 !is_aligned(operand_block.src_ptr, PAGE_ALIGN_LG)) begin
      chk_gp = 1'b1;
    end else if (concurrency.target_busy || concurrency.slot_busy ||
                 concurrency.ctrl_busy || concurrency.slot_page_changing) begin
      chk_gp = 1'b1;
    end else if (concurrency.tracking_busy) begin
      chk_gp = 1'b1;
    end else if (!target_entry.valid) begin
      chk_pf    = 1'b1;
      chk_faddr = page_addr_reg;
    end else if (!slot_page_entry.valid ||
                 slot_page_entry.ptype != version_array_type) begin
      chk_pf    = 1'b1;
      chk_faddr = slot_addr_reg;
    end else if (child_type(target_entry.ptype) &&
                 !owner_info.blocking_ok) begin
      chk_gp = 1'b1;
    end else if (child_type(target_entry.ptype)) begin
      if (!target_entry.blocked) begin
        chk_stop = 1'b1;
        chk_code = not_blocked_code;
      end else if (!owner_info.tracking_ok) begin
        chk_stop = 1'b1;
        chk_code = not_tracked_code;
      end else begin
        chk_hdr_id   = owner_info.enclave_identifier;
        chk_meta_id  = owner_info.enclave_identifier;
      end
    end else if (target_entry.ptype == enclave_control_type) begin
      if (owner_info.child_present) begin
        chk_stop = 1'b1;
        chk_code = child_present_code;
      end else begin
        chk_hdr_id   = 64'h0;
        chk_meta_id  = owner_info.self_identifier;
      end
    end else if (target_entry.ptype == version_array_type) begin
      chk_hdr_id   = 64'h0;
      chk_meta_id  = 64'h0;
    end else begin
      chk_pf    = 1'b1;
      chk_faddr = page_addr_reg;
    end
  end

  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:    state_next = start_cmd ? ST_CHECK : ST_IDLE;
      ST_CHECK:   state_next = (chk_gp || chk_pf || chk_stop) ?
                               ST_FINISH : ST_ENCRYPT;
      ST_ENCRYPT: state_next = gcm_done ? ST_WRITE : ST_ENCRYPT;
      ST_WRITE:  state_next = ST_INVAL;
      ST_INVAL:  state_next = ST_FINISH;
      ST_FINISH: state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // result code and flags
  always_ff @(posedge clk) begin
    if (rst) begin
      result_reg <= success_code;
      flags_reg  <= '0;
    end else if (state_reg == ST_CHECK && !chk_gp && !chk_pf) begin
      result_reg <= chk_code;
      flags_reg  <= FLAG_W'(chk_stop);
    end else if (state_reg == ST_WRITE && slot_value != 64'h0) begin
      result_reg <= slot_occupied_code;
      flags_reg[ST_CARRY - ST_ZERO] <= 1'b1;
    end
  end

  // fault capture and completion
  always_ff @(posedge clk) begin
    if (rst) begin
      gp_reg         <= 1'b0;
      pf_reg         <= 1'b0;
      fault_addr_reg <= 64'h0;
      done_reg       <= 1'b0;
    end else if (start_cmd) begin
      gp_reg   <= 1'b0;
      pf_reg   <= 1'b0;
      done_reg <= 1'b0;
    end else if (state_reg == ST_CHECK) begin
      gp_reg         <= chk_gp;
      pf_reg         <= chk_pf;
      fault_addr_reg <= chk_faddr;
    end else if (state_reg == ST_FINISH) begin
      done_reg <= 1'b1;
    end
  end

  // identifiers and pointers kept for the later cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      hdr_id_reg   <= 64'h0;
      meta_id_reg  <= 64'h0;
      meta_ptr_reg <= 64'h0;
      src_ptr_reg  <= 64'h0;
    end else if (state_reg == ST_CHECK) begin
      hdr_id_reg   <= chk_hdr_id;
      meta_id_reg  <= chk_meta_id;
      meta_ptr_reg <= operand_block.meta_ptr;
      src_ptr_reg  <= operand_block.src_ptr;
    end
  end

  // encryption request
  always_ff @(posedge clk) begin
    if (rst) begin
      gcm_start    <= 1'b0;
      gcm_counter  <= 96'h0;
      gcm_header   <= '0;
      gcm_src_addr <= 64'h0;
      gcm_dst_addr <= 64'h0;
    end else begin
      gcm_start <= (state_reg == ST_CHECK) && (state_next == ST_ENCRYPT);
      if (state_reg == ST_CHECK && state_next == ST_ENCRYPT) begin
        gcm_counter  <= {version_value_reg, 32'h0};
        gcm_header   <= '{target_entry.lin_addr, target_entry.ptype,
          target_entry.access_permissions, target_entry.pending,
          target_entry.modified, target_entry.permission_restrict_bit,
          chk_hdr_id};
        gcm_src_addr <= page_addr_reg;
        gcm_dst_addr <= operand_block.src_ptr;
      end
    end
  end

  // metadata, returned address and version slot writes
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_wr       <= 1'b0;
      meta_addr     <= 64'h0;
      meta_data     <= '0;
      lin_return_wr <= 1'b0;
      lin_return    <= 64'h0;
      slot_wr       <= 1'b0;
      slot_addr     <= 64'h0;
      slot_wdata    <= 64'h0;
    end else begin
      meta_wr       <= (state_reg == ST_ENCRYPT) && gcm_done;
      lin_return_wr <= (state_reg == ST_ENCRYPT) && gcm_done;
      slot_wr       <= (state_reg == ST_WRITE);
      if (state_reg == ST_ENCRYPT && gcm_done) begin
        meta_addr <= meta_ptr_reg;
        meta_data <= '{target_entry.ptype, target_entry.access_permissions,
          target_entry.pending, target_entry.modified,
          target_entry.permission_restrict_bit, meta_id_reg,
          gcm_tag};
        lin_return <= target_entry.lin_addr;
      end
      if (state_reg == ST_WRITE) begin
        slot_addr  <= slot_addr_reg;
        slot_wdata <= version_value_reg;
      end
    end
  end

  // page map entry release after the slot write
  always_ff @(posedge clk) begin
    if (rst) begin
      map_invalidate      <= 1'b0;
      map_invalidate_addr <= 64'h0;
    end else begin
      map_invalidate <= (state_reg == ST_INVAL);
      if (state_reg == ST_INVAL) begin
        map_invalidate_addr <= page_addr_reg;
      end
    end
  end

  // fault pulses leave with the check result
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_gp   <= 1'b0;
      fault_pf   <= 1'b0;
      fault_addr <= 64'h0;
    end else begin
      fault_gp <= (state_reg == ST_CHECK) && chk_gp;
      fault_pf <= (state_reg == ST_CHECK) && chk_pf;
      if (state_reg == ST_CHECK) begin
        fault_addr <= chk_faddr;
      end
    end
  end

  assign busy = (state_reg != ST_IDLE);

  // register read, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      case (reg_addr)
        OFF_OPERAND:    reg_rdata <= operand_addr_reg;
        OFF_PAGE:       reg_rdata <= page_addr_reg;
        OFF_SLOT:       reg_rdata <= slot_addr_reg;
        OFF_VERSION:    reg_rdata <= version_value_reg;
        OFF_RESULT:     reg_rdata <= {56'h0, result_reg};
        OFF_FAULT_ADDR: reg_rdata <= fault_addr_reg;
        OFF_STATUS: begin
          reg_rdata[ST_BUSY]              <= busy;
          reg_rdata[ST_DONE]              <= done_reg;
          reg_rdata[ST_SIGN:ST_ZERO]      <= flags_reg;
          reg_rdata[ST_GP]                <= gp_reg;
          reg_rdata[ST_PF]                <= pf_reg;
        end
        default: ;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : enclave_page_writeback

// file: gcm_engine_model.sv
`timescale 1ns/1ps
module gcm_engine_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         gcm_start,
  input  wire logic [95:0]  gcm_counter,
  input  wire logic [3:0]   dly,
  output logic              gcm_done,
  output logic [127:0]      gcm_tag
);
  logic [4:0]   cnt_reg;
  logic [127:0] tag_reg;
  // tag stands only with done; inverted otherwise so stale use shows
  assign gcm_tag = gcm_done ? tag_reg : ~tag_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 5'h0;
    end else if (gcm_start) begin
      cnt_reg <= {1'b0, dly} + 5'h1;
      tag_reg <= {gcm_counter[95:32] ^ 64'ha5a5_a5a5_a5a5_a5a5,
                  64'h0f0f_0f0f_0f0f_0f0f};
    end else if (cnt_reg != 5'h0) begin
      cnt_reg <= cnt_reg - 5'h1;
    end
  end
  always_ff @(posedge clk) begin
    gcm_done <= !rst && cnt_reg == 5'h1;
  end
endmodule : gcm_engine_model

// file: page_writeback_pkg.sv
package page_writeback_pkg;

  // register port
  localparam int          REG_AW         = 8;
  localparam int          REG_DW         = 64;
  localparam logic [7:0]  OFF_CONTROL    = 8'h00;
  localparam logic [7:0]  OFF_OPERAND    = 8'h04;
  localparam logic [7:0]  OFF_PAGE       = 8'h08;
  localparam logic [7:0]  OFF_SLOT       = 8'h0c;
  localparam logic [7:0]  OFF_VERSION    = 8'h10;
  localparam logic [7:0]  OFF_RESULT     = 8'h14;
  localparam logic [7:0]  OFF_STATUS     = 8'h18;
  localparam logic [7:0]  OFF_FAULT_ADDR = 8'h1c;
  localparam int          CTRL_START_BIT = 0;

  // status fields
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_ZERO     = 2;
  localparam int ST_CARRY    = 3;
  localparam int ST_PARITY   = 4;
  localparam int ST_AUX      = 5;
  localparam int ST_OVERFLOW = 6;
  localparam int ST_SIGN     = 7;
  localparam int ST_GP       = 8;
  localparam int ST_PF       = 9;
  localparam int FLAG_W      = 6;

  // alignment, as log2 of bytes; then header and page size in bytes, counter shift in bits
  localparam int OPERAND_ALIGN_LG = 5;
  localparam int PAGE_ALIGN_LG    = 12;
  localparam int SLOT_ALIGN_LG    = 3;
  localparam int META_ALIGN_LG    = 7;
  localparam int HEADER_BYTES     = 128;
  localparam int PAGE_BYTES       = 4096;
  localparam int COUNTER_SHIFT    = 32;

  // page types
  localparam logic [7:0] enclave_control_type = 8'h00;
  localparam logic [7:0] thread_control_type  = 8'h01;
  localparam logic [7:0] regular_page_type    = 8'h02;
  localparam logic [7:0] version_array_type   = 8'h03;
  localparam logic [7:0] trimmed_page_type    = 8'h04;

  // result codes
  localparam logic [7:0] success_code       = 8'h00;
  localparam logic [7:0] not_blocked_code   = 8'h01;
  localparam logic [7:0] not_tracked_code   = 8'h02;
  localparam logic [7:0] slot_occupied_code = 8'h03;
  localparam logic [7:0] child_present_code = 8'h04;

  typedef struct packed {
    logic        valid;
    logic [7:0]  ptype;
    logic [2:0]  access_permissions;
    logic        pending;
    logic        modified;
    logic        permission_restrict_bit;
    logic        blocked;
    logic [63:0] lin_addr;
  } page_map_entry_t;

  typedef struct packed {
    logic [63:0] lin_addr;
    logic [63:0] ctrl_ptr;
    logic [63:0] meta_ptr;
    logic [63:0] src_ptr;
  } operand_block_t;

  typedef struct packed {
    logic [63:0] enclave_identifier;
    logic [63:0] self_identifier;
    logic        blocking_ok;
    logic        tracking_ok;
    logic        child_present;
  } owner_info_t;

  typedef struct packed {
    logic target_busy;
    logic slot_busy;
    logic ctrl_busy;
    logic slot_page_changing;
    logic tracking_busy;
  } concurrency_t;

  typedef struct packed {
    logic [63:0] lin_addr;
    logic [7:0]  ptype;
    logic [2:0]  access_permissions;
    logic        pending;
    logic        modified;
    logic        permission_restrict_bit;
    logic [63:0] enclave_identifier;
  } auth_header_t;

  typedef struct packed {
    logic [7:0]   ptype;
    logic [2:0]   access_permissions;
    logic         pending;
    logic         modified;
    logic         permission_restrict_bit;
    logic [63:0]  enclave_identifier;
    logic [127:0] tag;
  } page_crypto_metadata_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_CHECK   = 3'b001,
    ST_ENCRYPT = 3'b011,
    ST_WRITE   = 3'b010,
    ST_INVAL   = 3'b110,
    ST_FINISH  = 3'b111
  } wb_state_t;

endpackage : page_writeback_pkg

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import page_writeback_pkg::*;
  localparam logic [63:0] PG  = 64'h8000_1000;
  localparam logic [63:0] SL  = 64'h8000_2008;
  localparam logic [63:0] VER = 64'h1234_5678_9abc_def0;
  logic clk, rst, reg_wr, reg_rd, gcm_start, gcm_done, meta_wr, slot_wr;
  logic lin_return_wr, map_invalidate, fault_gp, fault_pf, busy;
  logic [7:0] reg_addr;
  logic [1:0] priv_level;
  logic [3:0] dly;
  logic [95:0] gcm_counter;
  logic [127:0] gcm_tag;
  logic [63:0] reg_wdata, reg_rdata, slot_value, gcm_src_addr, gcm_dst_addr;
  logic [63:0] meta_addr, lin_return, slot_addr, slot_wdata, fault_addr;
  logic [63:0] map_invalidate_addr, oa, pa, sa;
  operand_block_t        operand_block;
  page_map_entry_t       target_entry, slot_page_entry;
  owner_info_t           owner_info;
  concurrency_t          concurrency;
  auth_header_t          gcm_header;
  page_crypto_metadata_t meta_data;
  int err_count, tests_run, n_gcm, n_meta, n_slot, n_inv, n_gp, n_pf, tg;

  enclave_page_writeback #(.CACHE_BASE(64'h8000_0000),
    .CACHE_SIZE(64'h100_0000)) uut (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .priv_level, .operand_block,
    .target_entry, .slot_page_entry, .owner_info, .concurrency, .slot_value,
    .gcm_start, .gcm_counter, .gcm_header, .gcm_src_addr, .gcm_dst_addr,
    .gcm_done, .gcm_tag, .meta_wr, .meta_addr, .meta_data, .lin_return_wr,
    .lin_return, .slot_wr, .slot_addr, .slot_wdata, .map_invalidate,
    .map_invalidate_addr, .fault_gp, .fault_pf, .fault_addr, .busy);
  gcm_engine_model partner (.clk, .rst, .gcm_start, .gcm_counter, .dly,
    .gcm_done, .gcm_tag);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [63:0] m, e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask : rd

  task automatic base();
    oa = 64'h1000;
    pa = PG;
    sa = SL;
    priv_level <= 2'd0;
    operand_block <= '{64'h0, 64'h0, 64'h2080, 64'h3000};
    target_entry <= '{1'b1, regular_page_type, 3'h5, 1'b0, 1'b1, 1'b1,
                      1'b1, 64'h7000};
    slot_page_entry <= '{valid: 1'b1, ptype: version_array_type, default: '0};
    owner_info <= '{64'h11, 64'h22, 1'b1, 1'b1, 1'b0};
    concurrency <= '0;
    slot_value <= 64'h0;
    dly <= 4'h1;
    @(posedge clk);
  endtask : base

  task automatic run();
    int k;
    {n_gcm, n_meta, n_slot, n_inv, n_gp, n_pf, tg} = '0;
    wr(OFF_OPERAND, oa);
    wr(OFF_PAGE, pa);
    wr(OFF_SLOT, sa);
    wr(OFF_VERSION, VER);
    wr(OFF_CONTROL, 64'h1);
    for (k = 1; k < 60; k++) begin
      @(posedge clk);
      #1;
      if (gcm_start === 1'b1) tg = k;
      n_gcm += int'(gcm_start === 1'b1);
      n_meta += int'(meta_wr === 1'b1 && lin_return_wr === 1'b1);
      n_slot += int'(slot_wr === 1'b1);
      n_inv += int'(map_invalidate === 1'b1);
      n_gp += int'(fault_gp === 1'b1);
      n_pf += int'(fault_pf === 1'b1);
      if (busy === 1'b0) break;
    end
    if (k == 60) begin
      err_count++;
      $display("[FAIL] %0t operation never ended", $time);
      give_verdict();
    end
  endtask : run

  task automatic t_types();
    logic [7:0] ty[5] = '{regular_page_type, thread_control_type,
      trimmed_page_type, enclave_control_type, version_array_type};
    for (int i = 0; i < 5; i++) begin
      base();
      target_entry.ptype <= ty[i];
      dly <= 4'(i * 3);
      run();
      chk(tg, 1);
      chk(gcm_counter[95:32], VER);
      chk({gcm_src_addr, gcm_dst_addr}, {PG, 64'h3000});
      chk(gcm_header.lin_addr, 64'h7000);
      chk({gcm_header.ptype, gcm_header.access_permissions,
           gcm_header.pending, gcm_header.modified,
           gcm_header.permission_restrict_bit}, {ty[i], 6'h2b});
      chk(gcm_header.enclave_identifier, i < 3 ? 64'h11 : 64'h0);
      chk({meta_data.ptype, meta_data.access_permissions,
           meta_data.pending, meta_data.modified,
           meta_data.permission_restrict_bit}, {ty[i], 6'h2b});
      chk(meta_data.enclave_identifier,
          i < 3 ? 64'h11 : i == 3 ? 64'h22 : 64'h0);
      chk(meta_data.tag[127:64], VER ^ 64'ha5a5_a5a5_a5a5_a5a5);
      chk({meta_addr, lin_return}, {64'h2080, 64'h7000});
      chk({slot_addr, slot_wdata}, {SL, VER});
      chk(map_invalidate_addr, PG);
      chk({n_meta, n_slot, n_inv, n_gcm}, {4{32'd1}});
      rd(OFF_RESULT, '1, success_code);
      rd(OFF_STATUS, 64'h3fe, 64'h2);
    end
  endtask : t_types

  task automatic t_occupied();
    base();
    slot_value <= 64'h1;
    run();
    chk({n_slot, n_inv}, {2{32'd1}});
    rd(OFF_RESULT, '1, slot_occupied_code);
    rd(OFF_STATUS, 64'h3fe, 64'ha);
  endtask : t_occupied

  task automatic t_stops();
    logic [7:0] code[3] = '{not_blocked_code, not_tracked_code,
                           child_present_code};
    for (int i = 0; i < 3; i++) begin
      base();
      if (i == 0) target_entry.blocked <= 1'b0;
      if (i == 1) owner_info.tracking_ok <= 1'b0;
      if (i == 2) target_entry.ptype <= enclave_control_type;
      if (i == 2) owner_info.child_present <= 1'b1;
      run();
      chk(n_gcm + n_meta + n_slot + n_inv, 0);
      rd(OFF_RESULT, '1, code[i]);
      rd(OFF_STATUS, 64'h3fe, 64'h6);
    end
  endtask : t_stops

  task automatic t_faults();
    int ek[17] = '{1, 1, 2, 1, 2, 1, 1, 1, 1, 1, 1, 1, 2, 2, 1, 1, 1};
    for (int i = 0; i < 17; i++) begin
      base();
      case (i)
        0: oa = 64'h1010;
        1: pa = PG + 64'h800;
        2: pa = 64'h1000;
        3: sa = SL + 64'h1;
        4: sa = 64'h2008;
        5: sa = PG + 64'h8;
        6: operand_block.lin_addr <= 64'h1;
        7: operand_block.meta_ptr <= 64'h2040;
        8: operand_block.src_ptr <= 64'h3100;
        9: concurrency.target_busy <= 1'b1;
        10: concurrency.slot_page_changing <= 1'b1;
        11: concurrency.tracking_busy <= 1'b1;
        12: target_entry.valid <= 1'b0;
        13: slot_page_entry.ptype <= regular_page_type;
        14: owner_info.blocking_ok <= 1'b0;
        15: priv_level <= 2'd3;
        default: operand_block.ctrl_ptr <= 64'h1;
      endcase
      run();
      chk(n_gcm + n_slot + n_inv, 0);
      if (ek[i] != 0) begin
        chk({n_gp, n_pf}, {32'(ek[i] == 1), 32'(ek[i] == 2)});
        rd(OFF_STATUS, 64'h300, ek[i] == 1 ? 64'h100 : 64'h200);
      end
      if (ek[i] == 2) rd(OFF_FAULT_ADDR, '1, i % 9 == 4 ? sa : pa);
    end
  endtask : t_faults

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {err_count, tests_run} = '0;
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 8'h0, 64'h0};
    base();
    repeat (19) @(posedge clk);
    rst <= 1'b0;
    t_types();
    t_occupied();
    t_stops();
    t_occupied();
    t_faults();
    rd(8'h40, '1, 64'h0);
    rd(OFF_CONTROL, '1, 64'h0);
    give_verdict();
  end
endmodule : testbench

bind enclave_page_writeback writeback_checker chk_i (.clk, .rst, .gcm_start,
  .gcm_counter, .gcm_src_addr, .gcm_done, .gcm_tag, .meta_wr, .meta_data,
  .lin_return_wr, .slot_wr, .slot_wdata, .map_invalidate,
  .map_invalidate_addr, .fault_gp, .fault_pf, .fault_addr, .busy);

// file: writeback_assertions.sv
`timescale 1ns/1ps
module writeback_checker
  import page_writeback_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  gcm_start,
  input wire logic [95:0]           gcm_counter,
  input wire logic [63:0]           gcm_src_addr,
  input wire logic                  gcm_done,
  input wire logic [127:0]          gcm_tag,
  input wire logic                  meta_wr,
  input wire page_crypto_metadata_t meta_data,
  input wire logic                  lin_return_wr,
  input wire logic                  slot_wr,
  input wire logic [63:0]           slot_wdata,
  input wire logic                  map_invalidate,
  input wire logic [63:0]           map_invalidate_addr,
  input wire logic                  fault_gp,
  input wire logic                  fault_pf,
  input wire logic [63:0]           fault_addr,
  input wire logic                  busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_counter_shift: assert property (
    gcm_start |-> gcm_counter[31:0] == 32'h0) else $error("counter low");
  a_meta_follow: assert property (
    gcm_done && busy |=> meta_wr && lin_return_wr) else $error("no meta");
  a_meta_tag: assert property (
    meta_wr |-> meta_data.tag == $past(gcm_tag)) else $error("tag lost");
  a_slot_then_inval: assert property (
    meta_wr |=> slot_wr ##1 map_invalidate) else $error("write order");
  a_slot_version: assert property (
    slot_wr |-> slot_wdata == gcm_counter[95:32]) else $error("slot data");
  a_inval_target: assert property (
    map_invalidate |-> map_invalidate_addr == gcm_src_addr)
    else $error("inval addr");
  a_gp_plain: assert property (
    fault_gp |-> fault_addr == 64'h0 && !fault_pf) else $error("gp addr");
  a_fault_ends: assert property (
    fault_gp || fault_pf |=> !busy && !gcm_start) else $error("fault end");
endmodule : writeback_checker
